// ===== fit_pkg.sv
// Shared constants and types of the two-wire memory target.
// Assumes a single 125 MHz system clock; the bus pins are asynchronous to it.
package fit_pkg;

    // Memory geometry
    localparam int              ADDR_W     = 16;
    localparam int              DATA_W     = 8;
    localparam int              MEM_DEPTH  = 65536;
    localparam logic [15:0]     ADDR_RESET = 16'h0000;
    localparam logic [15:0]     ADDR_LAST  = 16'hffff;

    // Addressing byte layout, most significant bit first on the wire
    localparam int              TYPE_MSB   = 7;
    localparam int              TYPE_LSB   = 4;
    localparam int              STRAP_MSB  = 3;
    localparam int              STRAP_LSB  = 1;
    localparam int              RW_POS     = 0;
    localparam logic            RW_READ    = 1'b1;

    // Bit counter runs 0..7 within a byte
    localparam logic [2:0]      BIT_FIRST  = 3'h0;
    localparam logic [2:0]      BIT_LAST   = 3'h7;
    localparam logic [7:0]      BYTE_ZERO  = 8'h00;

    // Sampled pin group; idle bus is high, open straps and write protect are low
    typedef struct packed {
        logic       scl;
        logic       sda;
        logic       wp;
        logic [2:0] strap;
    } fit_pins_t;

    localparam int              PINS_W   = 6;
    localparam fit_pins_t       PINS_RST = 6'h30;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_RX,
        ST_PREACK,
        ST_ACK,
        ST_TX,
        ST_TXEND,
        ST_RACK,
        ST_TXNEXT,
        ST_HOLD
    } fit_state_t;

    typedef enum logic [1:0] {
        PH_DEV,
        PH_AHI,
        PH_ALO,
        PH_DATA
    } fit_phase_t;

endpackage

// ===== fit_sync.sv
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes the levels are quasi-static between bus clock edges.
module fit_sync #(
    parameter int                 WIDTH   = 1,
    parameter logic [WIDTH-1:0]   RST_VAL = '0
) (
    // System
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    // Levels
    input  wire logic [WIDTH-1:0]   d,
    output logic      [WIDTH-1:0]   q
);

    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            meta <= RST_VAL;
            q    <= RST_VAL;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule // fit_sync

// ===== fit_target.sv
// Two-wire serial target with a 64K x 8 memory array behind it.
// Assumes the bus controller drives SCL well below a quarter of clk_sys.
//
// How it works
// RL1: Array holds 65536 bytes reached by a 16-bit address.
// RL2: Up to eight targets share the bus, told apart by straps.
// RL3: Take part only when received address code equals strapped pins.
// RL4: Open strap pins count as low.
// RL5: SDA is only pulled low or released, never driven high.
// RL6: Sample SDA on SCL rising edge, change it on falling edge.
// RL7: Write protect high blocks array writes; low lets all be written.
// RL8: Reads always work regardless of write protect.
// RL9: Act only as target, never start a transfer.
// RL10: Controller starts every transfer and supplies the clock.
// RL11: SDA changes only while SCL low, except start and stop.
// RL12: Start is SDA falling while SCL high; detected here.
// RL13: Stop is SDA rising while SCL high; detected here.
// RL14: Stop during a read ends it and returns to standby.
// RL15: Stop during a write ends write data and returns to standby.
// RL16: After a write stop, a new transfer is accepted at once.
// RL17: Addresses and data move as bytes, each followed by acknowledge.
// RL18: Receiver pulls SDA low on the ninth clock to acknowledge.
// RL19: Transmitter releases SDA on the ninth clock to sample acknowledge.
// RL20: Stop before acknowledge aborts and enters standby.
// RL21: After a not-acknowledge the bus is released.
// RL22: Controller then sends stop or repeated start.
// RL23: First byte: type code, three address bits high first, direction.
// RL24: Direction 0 writes, 1 reads.
// RL25: Write or set-up sends two address bytes, high first, each acknowledged.
// RL26: Address advances per data byte and wraps to zero.
// RL27: Pins synchronised; edges, start, stop found from samples; mismatch idles.
module fit_target #(
    // Device type code; value is arbitrary
    parameter logic [3:0] DEV_TYPE = 4'h5
) (
    // System
    input  wire logic   clk_sys,
    input  wire logic   rst_n,
    // Two-wire bus
    input  wire logic   scl,
    input  wire logic   sda_in,
    output logic        sda_out,
    output logic        sda_oe_n,
    // Straps and protection
    input  wire logic   wp,
    input  wire logic   addr_strap_bit0,
    input  wire logic   addr_strap_bit1,
    input  wire logic   addr_strap_bit2,
    // Status
    output logic        busy,
    output logic        write_refused
);

    fit_pkg::fit_pins_t         pin_raw;
    fit_pkg::fit_pins_t         pin_s;
    logic                       scl_q;
    logic                       sda_q;
    logic                       scl_rise;
    logic                       scl_fall;
    logic                       start_det;
    logic                       stop_det;
    fit_pkg::fit_state_t        state;
    fit_pkg::fit_phase_t        phase;
    logic [2:0]                 bit_cnt;
    logic [7:0]                 rx_shift;
    logic [7:0]                 next_byte;
    logic [7:0]                 tx_shift;
    logic [7:0]                 addr_hi;
    logic                       rd_mode;
    logic                       dev_match;
    logic                       rx_done;
    logic                       tx_load;
    logic                       wr_strobe;
    logic [15:0]                mem_addr;
    logic [7:0]                 mem [fit_pkg::MEM_DEPTH];
    logic [7:0]                 rd_byte;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Pins are asynchronous; open straps arrive low through pull-downs
    assign pin_raw = {scl, sda_in, wp, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0}; // see RL4

    fit_sync #(
        .WIDTH   (fit_pkg::PINS_W),
        .RST_VAL (fit_pkg::PINS_RST)
    ) u_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .d       (pin_raw),
        .q       (pin_s)
    ); // see RL27

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= pin_s.scl;
            sda_q <= pin_s.sda;
        end
    end

    // Edge and condition detection on synchronised samples only
    assign scl_rise  = pin_s.scl & ~scl_q;                           // see RL6
    assign scl_fall  = ~pin_s.scl & scl_q;                           // see RL6
    assign start_det = scl_q & pin_s.scl & sda_q & ~pin_s.sda;       // see RL12
    assign stop_det  = scl_q & pin_s.scl & ~sda_q & pin_s.sda;       // see RL13

    assign next_byte = {rx_shift[6:0], pin_s.sda};
    assign dev_match = (next_byte[fit_pkg::TYPE_MSB:fit_pkg::TYPE_LSB] == DEV_TYPE) &&
                       (next_byte[fit_pkg::STRAP_MSB:fit_pkg::STRAP_LSB] == pin_s.strap); // see RL2, RL3, RL23

    assign rx_done   = (state == fit_pkg::ST_RX) && scl_rise && (bit_cnt == fit_pkg::BIT_LAST); // see RL17
    assign tx_load   = scl_fall && (((state == fit_pkg::ST_ACK) && rd_mode) ||
                                    (state == fit_pkg::ST_TXNEXT));
    // Write protect gates only the store, never the handshake or reads
    assign wr_strobe = rx_done && (phase == fit_pkg::PH_DATA) && !pin_s.wp;     // see RL7
    assign rd_byte   = mem[mem_addr];                                           // see RL8

    // Controller and pin drive; stop and start take priority over everything but reset
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state    <= fit_pkg::ST_IDLE;
            phase    <= fit_pkg::PH_DEV;
            bit_cnt  <= fit_pkg::BIT_FIRST;
            rx_shift <= fit_pkg::BYTE_ZERO;
            tx_shift <= fit_pkg::BYTE_ZERO;
            addr_hi  <= fit_pkg::BYTE_ZERO;
            rd_mode  <= 1'b0;
            sda_oe_n <= 1'b1;
        end else if (stop_det) begin
            state    <= fit_pkg::ST_IDLE;                   // see RL14, RL15, RL20
            sda_oe_n <= 1'b1;
            rd_mode  <= 1'b0;
        end else if (start_det) begin
            state    <= fit_pkg::ST_RX;                     // see RL12, RL16
            phase    <= fit_pkg::PH_DEV;
            bit_cnt  <= fit_pkg::BIT_FIRST;
            rd_mode  <= 1'b0;
            sda_oe_n <= 1'b1;
        end else begin
            case (state)
                fit_pkg::ST_IDLE: begin
                    sda_oe_n <= 1'b1;                       // see RL9
                end
                fit_pkg::ST_RX: begin
                    if (scl_rise) begin
                        rx_shift <= next_byte;
                        bit_cnt  <= bit_cnt + 3'h1;
                        if (bit_cnt == fit_pkg::BIT_LAST) begin
                            state <= fit_pkg::ST_PREACK;
                            case (phase)
                                fit_pkg::PH_DEV: begin
                                    if (dev_match) begin
                                        rd_mode <= (next_byte[fit_pkg::RW_POS] == fit_pkg::RW_READ); // see RL24
                                    end else begin
                                        state <= fit_pkg::ST_IDLE;  // see RL3, RL27
                                    end
                                end
                                fit_pkg::PH_AHI: begin
                                    addr_hi <= next_byte;           // see RL25
                                end
                                default: begin
                                end
                            endcase
                        end
                    end
                end
                fit_pkg::ST_PREACK: begin
                    if (scl_fall) begin
                        sda_oe_n <= 1'b0;                   // see RL18
                        state    <= fit_pkg::ST_ACK;
                    end
                end
                fit_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt <= fit_pkg::BIT_FIRST;
                        if (rd_mode) begin
                            sda_oe_n <= rd_byte[7];         // see RL5, RL6
                            tx_shift <= {rd_byte[6:0], 1'b0};
                            state    <= fit_pkg::ST_TX;
                        end else begin
                            sda_oe_n <= 1'b1;
                            state    <= fit_pkg::ST_RX;
                            if (phase != fit_pkg::PH_DATA) begin
                                phase <= fit_pkg::fit_phase_t'(phase + 2'h1);  // see RL25
                            end
                        end
                    end
                end
                fit_pkg::ST_TX: begin
                    if (scl_rise) begin
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == fit_pkg::BIT_LAST) begin
                            state <= fit_pkg::ST_TXEND;
                        end
                    end else if (scl_fall) begin
                        sda_oe_n <= tx_shift[7];            // see RL6, RL11
                        tx_shift <= {tx_shift[6:0], 1'b0};
                    end
                end
                fit_pkg::ST_TXEND: begin
                    if (scl_fall) begin
                        sda_oe_n <= 1'b1;                   // see RL19
                        state    <= fit_pkg::ST_RACK;
                    end
                end
                fit_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        state <= pin_s.sda ? fit_pkg::ST_HOLD : fit_pkg::ST_TXNEXT; // see RL21
                    end
                end
                fit_pkg::ST_TXNEXT: begin
                    if (scl_fall) begin
                        bit_cnt  <= fit_pkg::BIT_FIRST;
                        sda_oe_n <= rd_byte[7];
                        tx_shift <= {rd_byte[6:0], 1'b0};
                        state    <= fit_pkg::ST_TX;
                    end
                end
                fit_pkg::ST_HOLD: begin
                    // Released; waits for the controller's stop or repeated start
                    sda_oe_n <= 1'b1;                       // see RL21, RL22
                end
                default: begin
                    state    <= fit_pkg::ST_IDLE;
                    sda_oe_n <= 1'b1;
                end
            endcase
        end
    end

    // Address pointer: set by the address bytes, advanced per data byte
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mem_addr <= fit_pkg::ADDR_RESET;
        end else if (rx_done && (phase == fit_pkg::PH_ALO)) begin
            mem_addr <= {addr_hi, next_byte};               // see RL1, RL25
        end else if ((rx_done && (phase == fit_pkg::PH_DATA)) || tx_load) begin
            mem_addr <= mem_addr + 16'h0001;                // see RL26
        end
    end

    // Array store is immediate, so no write wait follows a stop
    always_ff @(posedge clk_sys) begin
        if (wr_strobe) begin
            mem[mem_addr] <= next_byte;                     // see RL1, RL16
        end
    end

    // Open-drain data: the pad value is held low, only the enable moves
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;                                // see RL5
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            busy          <= 1'b0;
            write_refused <= 1'b0;
        end else begin
            busy          <= (state != fit_pkg::ST_IDLE);
            write_refused <= rx_done && (phase == fit_pkg::PH_DATA) && pin_s.wp; // see RL7
        end
    end

    chk_pad_low: assert property (sda_out == 1'b0) // see RL5
        else $error("sda pad value not low");

    chk_stop_idle: assert property (stop_det |=> (state == fit_pkg::ST_IDLE) && sda_oe_n) // see RL14
        else $error("stop did not return to standby");

    chk_start_rx: assert property (start_det |=> (state == fit_pkg::ST_RX) && (bit_cnt == 3'h0)) // see RL12
        else $error("start did not begin byte reception");

    chk_drive_on_fall: assert property ($changed(sda_oe_n) |-> $past(scl_fall | start_det | stop_det)) // see RL6
        else $error("sda drive changed away from falling scl");

    chk_mismatch_idle: assert property
        (rx_done && (phase == fit_pkg::PH_DEV) && !dev_match |=> (state == fit_pkg::ST_IDLE) [*2]) // see RL3
        else $error("mismatched address not ignored");

    chk_ack_low: assert property
        ((state == fit_pkg::ST_PREACK) && scl_fall && !stop_det && !start_det |=> !sda_oe_n) // see RL18
        else $error("acknowledge not driven low");

    chk_wp_block: assert property
        (rx_done && (phase == fit_pkg::PH_DATA) && pin_s.wp |-> !wr_strobe ##1 write_refused) // see RL7
        else $error("protected write reached the array");

    chk_nack_release: assert property
        ((state == fit_pkg::ST_RACK) && scl_rise && pin_s.sda |=> (state == fit_pkg::ST_HOLD) && sda_oe_n) // see RL21
        else $error("bus not released after not-acknowledge");

    chk_ack_window: assert property
        ((state == fit_pkg::ST_TXEND) && scl_fall && !stop_det |=> sda_oe_n) // see RL19
        else $error("transmitter held sda in acknowledge clock");

    chk_addr_wrap: assert property
        (tx_load && (mem_addr == fit_pkg::ADDR_LAST) |=> mem_addr == fit_pkg::ADDR_RESET) // see RL26
        else $error("address did not wrap to zero");

    chk_idle_quiet: assert property ((state == fit_pkg::ST_IDLE) && $past(state == fit_pkg::ST_IDLE) |-> sda_oe_n) // see RL9
        else $error("sda driven while idle");

    cov_write_byte: cover property (wr_strobe);
    cov_read_byte:  cover property (tx_load ##[1:1000] (state == fit_pkg::ST_TXEND));
    cov_mismatch:   cover property (rx_done && (phase == fit_pkg::PH_DEV) && !dev_match);
    cov_nack_stop:  cover property ((state == fit_pkg::ST_HOLD) ##[1:1000] stop_det);

endmodule // fit_target

// ===== fit_ctrl_model.sv
// Behavioural two-wire bus controller that drives the memory target.
// Assumes a pull-up on SDA and an 8 ns clk_sys; one SCL period is ten clocks.
module fit_ctrl_model (
    // System
    input  wire logic clk_sys,
    // Bus
    input  wire logic sda_oe_n,
    output logic      scl,
    output logic      sda_line
);
    timeunit 1ns;
    timeprecision 100ps;

    logic drv_low;

    // Wired-AND with a pull-up: a released line reads high
    assign sda_line = ~(drv_low | ~sda_oe_n);

    initial begin
        scl     = 1'b1;
        drv_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Serves from idle and as a repeated start
    task automatic send_start();
        drv_low = 1'b0;
        tick(3);
        scl = 1'b1;
        tick(5);
        drv_low = 1'b1;
        tick(5);
        scl = 1'b0;
    endtask

    task automatic send_stop();
        tick(2);
        drv_low = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(5);
        drv_low = 1'b0;
        tick(5);
    endtask

    // Data moves two clocks after SCL falls, so it never races the clock edge
    task automatic bit_cycle(input logic b, output logic s);
        tick(2);
        drv_low = ~b;
        tick(3);
        scl = 1'b1;
        tick(5);
        s = sda_line;
        scl = 1'b0;
    endtask

    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cycle(d[i], s);
        bit_cycle(1'b1, s);
        ack = ~s;
    endtask

    task automatic read_byte(input logic ack_out, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, s);
            d[i] = s;
        end
        bit_cycle(~ack_out, s);
    endtask
endmodule // fit_ctrl_model

// ===== fit_target_bench.sv
// Self-checking bench for the two-wire memory target.
// Assumes fit_ctrl_model as the bus controller and an 8 ns system clock.
module fit_target_bench;
    timeunit 1ns;
    timeprecision 100ps;

    // Type code; value is arbitrary
    localparam logic [3:0] TYPE_CODE = 4'h5;

    typedef struct packed {
        logic [2:0] strap;
        logic [7:0] addr_byte;
        logic       ack;
    } fit_row_t;

    logic       clk_sys, rst_n, wp, sda_out, sda_oe_n, busy, write_refused;
    logic       scl, sda_line, ack;
    logic [2:0] strap;
    logic [7:0] rd;
    int         fail_count, checked, refused_seen, drove_high;

    // Every strap value matched, then a wrong strap and a wrong type code
    fit_row_t rows [10] = '{'{3'h0, 8'h50, 1'b1}, '{3'h1, 8'h52, 1'b1}, '{3'h2, 8'h54, 1'b1},
                            '{3'h3, 8'h56, 1'b1}, '{3'h4, 8'h58, 1'b1}, '{3'h5, 8'h5a, 1'b1},
                            '{3'h6, 8'h5c, 1'b1}, '{3'h7, 8'h5e, 1'b1}, '{3'h3, 8'h58, 1'b0},
                            '{3'h3, 8'h66, 1'b0}};

    fit_target #(.DEV_TYPE(TYPE_CODE)) uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .wp(wp), .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
        .addr_strap_bit2(strap[2]), .busy(busy), .write_refused(write_refused));

    fit_ctrl_model m (.clk_sys(clk_sys), .sda_oe_n(sda_oe_n), .scl(scl), .sda_line(sda_line));

    initial clk_sys = 1'b0;
    always #4 clk_sys = ~clk_sys;

    // Outputs are sampled mid-cycle, away from the edge that launches them
    always @(negedge clk_sys) begin
        if (write_refused === 1'b1) refused_seen++;
        if (sda_out !== 1'b0) drove_high++;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    function automatic logic [7:0] dev(input logic rw);
        return {TYPE_CODE, strap, rw};
    endfunction

    task automatic wb(input logic [7:0] d, input logic exp_ack);
        m.write_byte(d, ack);
        check("ack", {7'h0, ack}, {7'h0, exp_ack});
    endtask

    task automatic set_ptr(input logic [15:0] a);
        m.send_start();
        wb(dev(1'b0), 1'b1);
        wb(a[15:8], 1'b1);
        wb(a[7:0], 1'b1);
    endtask

    task automatic finish_idle();
        m.send_stop();
        @(negedge clk_sys);
        check("busy", {7'h0, busy}, 8'h00);
        check("released", {7'h0, sda_oe_n}, 8'h01);
    endtask

    task automatic read_one(input logic [7:0] exp);
        m.send_start();
        wb(dev(1'b1), 1'b1);
        m.read_byte(1'b0, rd);
        check("read", rd, exp);
    endtask

    initial begin
        rst_n = 1'b0;
        wp = 1'b0;
        strap = 3'h0;
        {fail_count, checked, refused_seen, drove_high} = '0;
        repeat (16) @(negedge clk_sys);
        check("oe in reset", {7'h0, sda_oe_n}, 8'h01);
        check("busy in reset", {7'h0, busy}, 8'h00);
        rst_n = 1'b1;
        repeat (8) @(negedge clk_sys);
        foreach (rows[i]) begin
            strap = rows[i].strap;
            m.send_start();
            wb(rows[i].addr_byte, rows[i].ack);
            finish_idle();
        end
        // Page write across the top of the array, then a transfer with no wait
        strap = 3'h5;
        set_ptr(16'hffff);
        wb(8'ha5, 1'b1);
        wb(8'h3c, 1'b1);
        m.send_stop();
        set_ptr(16'hffff);
        read_one(8'ha5);
        // Next byte has a low top bit, so a device that kept sending would pull low
        repeat (6) @(negedge clk_sys);
        check("nack release", {7'h0, sda_oe_n}, 8'h01);
        finish_idle();
        read_one(8'h3c);
        finish_idle();
        // Protected write is acknowledged but leaves the array untouched
        set_ptr(16'h1234);
        wb(8'h11, 1'b1);
        m.send_stop();
        wp = 1'b1;
        set_ptr(16'h1234);
        wb(8'h77, 1'b1);
        m.send_stop();
        check("refused", 8'(refused_seen), 8'h01);
        set_ptr(16'h1234);
        read_one(8'h11);
        finish_idle();
        wp = 1'b0;
        // Stop inside the high address byte, before its acknowledge
        m.send_start();
        wb(dev(1'b0), 1'b1);
        for (int i = 0; i < 4; i++) m.bit_cycle(1'b0, ack);
        finish_idle();
        m.send_start();
        wb(dev(1'b0), 1'b1);
        finish_idle();
        // Reset in mid-read must drop the drive and bring the pointer back to zero
        set_ptr(16'h0000);
        m.send_start();
        wb(dev(1'b1), 1'b1);
        repeat (4) @(negedge clk_sys);
        check("read drive", {7'h0, sda_oe_n}, 8'h00);
        rst_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        check("oe mid reset", {7'h0, sda_oe_n}, 8'h01);
        check("busy mid reset", {7'h0, busy}, 8'h00);
        rst_n = 1'b1;
        repeat (8) @(negedge clk_sys);
        m.send_stop();
        read_one(8'h3c);
        finish_idle();
        check("open drain", 8'(drove_high), 8'h00);
        give_verdict();
    end

    // Whole run needs well under 100 us of bus traffic
    initial begin
        #400000;
        fail_count++;
        give_verdict();
    end
endmodule // fit_target_bench
